//--- hdl/exec_pkg.sv
// Constants, operation codes and carrier structs for the execution datapath.
// Assumes a decoder in front that supplies decoded operations with operand values already read.
// How it works
// - Register add, and add with carry, finish in one cycle and update Z,C,N,V,H.
// - Register or immediate subtract, with or without borrow, one cycle, updates Z,C,N,V,H.
// - Word immediate add/subtract on a register pair takes two cycles, updates Z,C,N,V,S.
// - And, or, exclusive-or take one cycle and update only Z, N, V and S.
// - Clear-bits ands with 0xFF minus the constant; set-bits ors with it.
// - Increment, decrement, test, clear update Z,N,V in one cycle; all-ones changes no flag.
// - Unsigned, signed and mixed multiply write pair one:zero in two cycles, update Z,C.
// - Fractional multiplies shift the product left one bit, two cycles, update Z,C.
// - Relative jump to PC plus offset plus one, indirect jump to Z; two cycles.
// - Relative and indirect calls push the return address, three cycles, flags untouched.
// - Compare-skip-equal skips next instruction on equality; one, two or three cycles.
// - Compares only set Z,N,V,S,C,H from a subtraction, write nothing, one cycle.
// - Register bit skips test one bit and skip on match, one to three cycles.
// - I/O bit skips test one I/O bit and skip on match, one to three cycles.
// - I/O single-bit set and clear are accepted only for addresses 0x00 to 0x1F.
// - I/O bit set and clear rewrite the whole register read beforehand.
// - Flag branches test the indexed flag; taken adds offset plus one, two cycles.
// - Unsigned branches test carry; equal and not-equal branches test zero.
// - Signed greater-or-equal branch taken when N xor V is zero.
// - Interrupt-enabled branch taken when the global interrupt flag is one.
package exec_pkg;

  localparam int PC_W = 12;
  localparam int SP_W = 10;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_STACK_PTR_LOW  = 6'h3d;
  localparam logic [5:0] IDX_STACK_PTR_HIGH = 6'h3e;
  localparam logic [5:0] IDX_STATUS_FLAGS   = 6'h3f;
  localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;

  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [7:0]      FLAGS_RESET = 8'h00;
  localparam logic [SP_W-1:0] SP_RESET    = 10'h000;
  localparam logic [PC_W-1:0] PC_RESET    = 12'h000;
  localparam logic [7:0]      ALL_ONES    = 8'hff;
  localparam logic [5:0]      IO_BIT_MAX  = 6'h1f;
  localparam logic [SP_W-1:0] PUSH_BYTES  = 10'h002;

  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  typedef enum logic [5:0] {
    op_nop, op_add, op_add_carry, op_sub, op_diff_with_borrow, op_word_imm_sum, op_word_imm_diff,
    op_and, op_or, op_xor, op_clear_bits_imm, op_set_bits_imm, op_inc, op_dec, op_test_zero_neg,
    op_clear_reg, op_load_all_ones, op_product_unsigned, op_product_signed, op_product_mixed,
    op_fractional_product, op_fractional_signed, op_fractional_mixed, op_jump_rel, op_jump_ind,
    op_relative_call, op_indirect_call, op_compare_skip_equal, op_compare, op_compare_carry,
    op_skip_reg_bit_clear, op_skip_reg_bit_set, op_skip_io_bit_clear, op_skip_io_bit_set,
    op_clear_io_bit, op_set_io_bit, op_branch_flag_set, op_branch_flag_clear, op_branch_unsigned_ge,
    op_branch_unsigned_lt, op_branch_equal, op_branch_not_equal, op_branch_signed_ge,
    op_branch_signed_lt, op_branch_int_enabled
  } op_t;

  typedef struct packed {
    op_t         op;
    logic        use_imm;
    logic [7:0]  rd_val;
    logic [7:0]  rd_hi_val;
    logic [7:0]  rr_val;
    logic [7:0]  imm;
    logic [2:0]  bit_sel;
    logic [11:0] offset;
    logic [15:0] z_ptr;
    logic        skip_two_word;
    logic [5:0]  io_addr;
    logic [7:0]  io_val;
  } exec_req_t;

  typedef struct packed {
    logic            wr_en;
    logic            wr_word;
    logic [15:0]     wr_data;
    logic            io_wr_en;
    logic [5:0]      io_addr;
    logic [7:0]      io_data;
    logic            push_en;
    logic [SP_W-1:0] push_addr;
    logic [15:0]     push_data;
    logic            refused;
  } exec_res_t;

endpackage

//--- hdl/cpu_alu_branch_exec.sv
// Execution datapath: ALU, multiplier, program counter, status flags and stack pointer.
// Assumes the decoder holds a request until ready and the register file writes back on done.
`timescale 1ns/1ps

module cpu_alu_branch_exec
  import exec_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Decoded operation
  input  wire logic        req_valid_i,
  input  wire exec_req_t   req_i,
  output logic             req_ready_o,
  output logic             done_o,
  output exec_res_t        res_o,
  output logic [PC_W-1:0]  pc_o,
  // Avalon-MM register slave
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o
);

  // ==========================================================================
  // State
  logic [7:0]      status_flags;
  logic [SP_W-1:0] stack_ptr;
  logic [PC_W-1:0] pc;
  logic [1:0]      remain;
  logic            done_q;
  logic            ack;
  exec_res_t       res_q;

  // ==========================================================================
  // Operand selection and shared arithmetic
  wire             take      = ce_i & req_valid_i & req_ready_o;
  wire op_t        op        = req_i.op;
  wire [7:0]       a         = req_i.rd_val;
  wire [7:0]       b         = req_i.use_imm ? req_i.imm : req_i.rr_val;
  wire             c_flag    = status_flags[FLAG_C];
  wire             cin_add   = (op == op_add_carry) & c_flag;
  wire             cin_sub   = ((op == op_diff_with_borrow) | (op == op_compare_carry)) & c_flag;
  wire [8:0]       sum9      = {1'b0, a} + {1'b0, b} + {8'h00, cin_add};
  wire [8:0]       diff9     = {1'b0, a} - {1'b0, b} - {8'h00, cin_sub};
  wire [15:0]      word_in   = {req_i.rd_hi_val, a};
  wire [15:0]      word_k    = {10'h000, req_i.imm[5:0]};
  wire [15:0]      word_sum  = word_in + word_k;
  wire [15:0]      word_diff = word_in - word_k;
  wire             a_signed  = (op == op_product_signed) | (op == op_product_mixed) |
                               (op == op_fractional_signed) | (op == op_fractional_mixed);
  wire             b_signed  = (op == op_product_signed) | (op == op_fractional_signed);
  wire [15:0]      mul_a     = {{8{a_signed & a[7]}}, a};
  wire [15:0]      mul_b     = {{8{b_signed & b[7]}}, b};
  wire [31:0]      prod32    = mul_a * mul_b;
  wire [15:0]      prod      = prod32[15:0];
  wire [PC_W-1:0]  pc_off    = PC_W'($signed(req_i.offset));
  wire [PC_W-1:0]  pc_rel    = pc + pc_off + PC_W'(1);
  wire [PC_W-1:0]  pc_seq    = pc + PC_W'(1);
  wire [PC_W-1:0]  pc_skip   = pc + (req_i.skip_two_word ? PC_W'(3) : PC_W'(2));
  wire [7:0]       bit_mask  = 8'h01 << req_i.bit_sel;
  wire             n_xor_v   = status_flags[FLAG_N] ^ status_flags[FLAG_V];
  wire             io_in_rng = req_i.io_addr <= IO_BIT_MAX;

  // Updates N, Z, V and S from an 8-bit result and its overflow.
  function automatic logic [7:0] nzv(input logic [7:0] f, input logic [7:0] r, input logic v);
    logic [7:0] o;
    o         = f;
    o[FLAG_N] = r[7];
    o[FLAG_Z] = (r == 8'h00);
    o[FLAG_V] = v;
    o[FLAG_S] = r[7] ^ v;
    return o;
  endfunction

  // ==========================================================================
  // Operation decode
  logic [7:0]      next_flags;
  logic [PC_W-1:0] next_pc;
  logic [SP_W-1:0] next_sp;
  logic [1:0]      cycles;
  exec_res_t       next_res;
  logic [7:0]      r8;
  logic            cond;

  always_comb
  begin
    next_flags        = status_flags;
    next_pc           = pc_seq;
    next_sp           = stack_ptr;
    cycles            = CYC_ONE;
    next_res          = '0;
    next_res.io_addr  = req_i.io_addr;
    r8                = 8'h00;
    cond              = 1'b0;
    unique case (op)
      op_add, op_add_carry:
      begin
        r8                = sum9[7:0];
        next_flags        = nzv(status_flags, r8, (a[7] & b[7] & ~r8[7]) | (~a[7] & ~b[7] & r8[7]));
        next_flags[FLAG_C] = sum9[8];
        next_flags[FLAG_H] = (a[3] & b[3]) | (b[3] & ~r8[3]) | (~r8[3] & a[3]);
        next_res.wr_en    = 1'b1;
      end
      op_sub, op_diff_with_borrow, op_compare, op_compare_carry:
      begin
        r8                = diff9[7:0];
        next_flags        = nzv(status_flags, r8, (a[7] & ~b[7] & ~r8[7]) | (~a[7] & b[7] & r8[7]));
        next_flags[FLAG_C] = diff9[8];
        next_flags[FLAG_H] = (~a[3] & b[3]) | (b[3] & r8[3]) | (r8[3] & ~a[3]);
        if (cin_sub)
          next_flags[FLAG_Z] = status_flags[FLAG_Z] & (r8 == 8'h00);
        next_res.wr_en    = (op == op_sub) | (op == op_diff_with_borrow);
      end
      op_word_imm_sum, op_word_imm_diff:
      begin
        cycles            = CYC_TWO;
        next_res.wr_en    = 1'b1;
        next_res.wr_word  = 1'b1;
        next_res.wr_data  = (op == op_word_imm_sum) ? word_sum : word_diff;
        next_flags[FLAG_N] = next_res.wr_data[15];
        next_flags[FLAG_Z] = (next_res.wr_data == 16'h0000);
        next_flags[FLAG_V] = (op == op_word_imm_sum) ? (~word_in[15] & next_res.wr_data[15])
                                                     : (word_in[15] & ~next_res.wr_data[15]);
        next_flags[FLAG_C] = (op == op_word_imm_sum) ? (~next_res.wr_data[15] & word_in[15])
                                                     : (next_res.wr_data[15] & ~word_in[15]);
        next_flags[FLAG_S] = next_flags[FLAG_N] ^ next_flags[FLAG_V];
      end
      op_and, op_or, op_xor, op_clear_bits_imm, op_set_bits_imm, op_test_zero_neg, op_clear_reg:
      begin
        unique case (op)
          op_and:            r8 = a & b;
          op_or:             r8 = a | b;
          op_xor:            r8 = a ^ b;
          op_clear_bits_imm: r8 = a & (ALL_ONES - req_i.imm);
          op_set_bits_imm:   r8 = a | req_i.imm;
          op_test_zero_neg:  r8 = a;
          default:           r8 = 8'h00;
        endcase
        next_flags     = nzv(status_flags, r8, 1'b0);
        next_res.wr_en = (op != op_test_zero_neg);
      end
      op_inc, op_dec:
      begin
        r8             = (op == op_inc) ? a + 8'h01 : a - 8'h01;
        next_flags     = nzv(status_flags, r8, (op == op_inc) ? (r8 == 8'h80) : (r8 == 8'h7f));
        next_res.wr_en = 1'b1;
      end
      op_load_all_ones:
      begin
        r8             = ALL_ONES;
        next_res.wr_en = 1'b1;
      end
      op_product_unsigned, op_product_signed, op_product_mixed:
      begin
        cycles             = CYC_TWO;
        next_res.wr_en     = 1'b1;
        next_res.wr_word   = 1'b1;
        next_res.wr_data   = prod;
        next_flags[FLAG_C] = prod[15];
        next_flags[FLAG_Z] = (prod == 16'h0000);
      end
      op_fractional_product, op_fractional_signed, op_fractional_mixed:
      begin
        cycles             = CYC_TWO;
        next_res.wr_en     = 1'b1;
        next_res.wr_word   = 1'b1;
        next_res.wr_data   = {prod[14:0], 1'b0};
        next_flags[FLAG_C] = prod[15];
        next_flags[FLAG_Z] = (prod[14:0] == 15'h0000);
      end
      op_jump_rel, op_jump_ind:
      begin
        cycles  = CYC_TWO;
        next_pc = (op == op_jump_rel) ? pc_rel : req_i.z_ptr[PC_W-1:0];
      end
      op_relative_call, op_indirect_call:
      begin
        cycles             = CYC_THREE;
        next_pc            = (op == op_relative_call) ? pc_rel : req_i.z_ptr[PC_W-1:0];
        next_res.push_en   = 1'b1;
        next_res.push_addr = stack_ptr;
        next_res.push_data = 16'(pc_seq);
        next_sp            = stack_ptr - PUSH_BYTES;
      end
      op_compare_skip_equal, op_skip_reg_bit_clear, op_skip_reg_bit_set, op_skip_io_bit_clear,
      op_skip_io_bit_set:
      begin
        unique case (op)
          op_compare_skip_equal: cond = (a == req_i.rr_val);
          op_skip_reg_bit_clear: cond = ~|(req_i.rr_val & bit_mask);
          op_skip_reg_bit_set:   cond = |(req_i.rr_val & bit_mask);
          op_skip_io_bit_clear:  cond = ~|(req_i.io_val & bit_mask);
          default:               cond = |(req_i.io_val & bit_mask);
        endcase
        if (cond)
        begin
          next_pc = pc_skip;
          cycles  = req_i.skip_two_word ? CYC_THREE : CYC_TWO;
        end
      end
      op_clear_io_bit, op_set_io_bit:
      begin
        next_res.refused = ~io_in_rng;
        if (io_in_rng)
        begin
          cycles            = CYC_TWO;
          next_res.io_wr_en = 1'b1;
          next_res.io_data  = (op == op_set_io_bit) ? (req_i.io_val | bit_mask) : (req_i.io_val & ~bit_mask);
        end
      end
      op_branch_flag_set, op_branch_flag_clear, op_branch_unsigned_ge, op_branch_unsigned_lt,
      op_branch_equal, op_branch_not_equal, op_branch_signed_ge, op_branch_signed_lt,
      op_branch_int_enabled:
      begin
        unique case (op)
          op_branch_flag_set:    cond = |(status_flags & bit_mask);
          op_branch_flag_clear:  cond = ~|(status_flags & bit_mask);
          op_branch_unsigned_ge: cond = ~c_flag;
          op_branch_unsigned_lt: cond = c_flag;
          op_branch_equal:       cond = status_flags[FLAG_Z];
          op_branch_not_equal:   cond = ~status_flags[FLAG_Z];
          op_branch_signed_ge:   cond = ~n_xor_v;
          op_branch_signed_lt:   cond = n_xor_v;
          default:               cond = status_flags[FLAG_I];
        endcase
        if (cond)
        begin
          next_pc = pc_rel;
          cycles  = CYC_TWO;
        end
      end
      default:
      begin
        r8 = 8'h00;
      end
    endcase
    if (next_res.wr_en & ~next_res.wr_word)
      next_res.wr_data = {8'h00, r8};
  end

  // ==========================================================================
  // Sequencing: an operation is taken when idle and completes after its cycle count.
  assign req_ready_o = (remain == 2'h0);
  assign done_o      = done_q;
  assign res_o       = res_q;
  assign pc_o        = pc;

  always_ff @(posedge core_clk_i)
    if (rst_i)
    begin
      remain <= 2'h0;
      done_q <= 1'b0;
      res_q  <= '0;
      pc     <= PC_RESET;
    end
    else if (ce_i)
    begin
      if (take)
      begin
        remain <= cycles - CYC_ONE;
        done_q <= (cycles == CYC_ONE);
        res_q  <= next_res;
        pc     <= next_pc;
      end
      else
      begin
        remain <= (remain != 2'h0) ? remain - 2'h1 : 2'h0;
        done_q <= (remain == 2'h1);
      end
    end

  // ==========================================================================
  // Avalon-MM slave: one wait state, read data registered.
  wire        hit_flags = (avs_address_i[7:2] == IDX_STATUS_FLAGS);
  wire        hit_sp_lo = (avs_address_i[7:2] == IDX_STACK_PTR_LOW);
  wire        hit_sp_hi = (avs_address_i[7:2] == IDX_STACK_PTR_HIGH);
  wire        bus_wr    = ce_i & avs_write_i & ack & avs_byteenable_i[0];
  wire [31:0] rd_word   = hit_flags ? {24'h00_0000, status_flags} :
                          hit_sp_lo ? {24'h00_0000, stack_ptr[7:0]} :
                          hit_sp_hi ? {22'h00_0000, stack_ptr[SP_W-1:8]} : UNMAPPED_READ;

  // Held high while frozen, so that no transfer is acknowledged without landing.
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~(ack & ce_i);

  always_ff @(posedge core_clk_i)
    if (rst_i)
    begin
      ack            <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack <= (avs_read_i | avs_write_i) & ~ack;
      if (avs_read_i & ~ack)
        avs_readdata_o <= rd_word;
    end

  // The datapath wins over a bus write landing in the same cycle.
  always_ff @(posedge core_clk_i)
    if (rst_i)
    begin
      status_flags <= FLAGS_RESET;
      stack_ptr    <= SP_RESET;
    end
    else if (ce_i)
    begin
      if (take)
        status_flags <= next_flags;
      else if (bus_wr & hit_flags)
        status_flags <= avs_writedata_i[7:0];
      if (take & next_res.push_en)
        stack_ptr <= next_sp;
      else if (bus_wr & hit_sp_lo)
        stack_ptr[7:0] <= avs_writedata_i[7:0];
      else if (bus_wr & hit_sp_hi)
        stack_ptr[SP_W-1:8] <= avs_writedata_i[SP_W-9:0];
    end

  // ==========================================================================
  // Checks
  default clocking chk_clk @(posedge core_clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence took(op_t o);
    take && req_i.op == o;
  endsequence

  add_one_cycle_a: assert property (took(op_add) |=> done_o && res_o.wr_en)
    else $error("add did not finish in one cycle");
  word_two_cycles_a: assert property (took(op_word_imm_diff) |=> !done_o ##1 done_o && res_o.wr_word)
    else $error("word subtract not two cycles");
  product_two_cycles_a: assert property (took(op_product_unsigned) |=> !done_o && !req_ready_o ##1 done_o)
    else $error("multiply not two cycles");
  call_three_cycles_a: assert property (took(op_relative_call)
    |=> (!done_o)[*2] ##1 done_o && res_o.push_en)
    else $error("call not three cycles");
  ones_flags_kept_a: assert property (took(op_load_all_ones) |=> status_flags == $past(status_flags))
    else $error("load all ones changed flags");
  compare_no_write_a: assert property (took(op_compare) |=> done_o && !res_o.wr_en)
    else $error("compare wrote a register");
  io_range_a: assert property ((took(op_set_io_bit) ##0 (req_i.io_addr > IO_BIT_MAX))
    |=> !res_o.io_wr_en && res_o.refused)
    else $error("io bit write outside range");
  indirect_jump_a: assert property (took(op_jump_ind) |=> pc == $past(req_i.z_ptr[PC_W-1:0]))
    else $error("indirect jump target wrong");
  signed_lt_a: assert property ((took(op_branch_signed_lt) ##0 !n_xor_v)
    |=> pc == $past(pc) + PC_W'(1) && done_o)
    else $error("signed less-than taken wrongly");

endmodule

//--- verification/testbench.sv
// Self-checking bench for the execution datapath: ALU, multiply, jumps, calls, skips, branches, I/O bits.
// Assumes exec_pkg and cpu_alu_branch_exec are compiled first; the bench drives every port itself.
`timescale 1ns/1ps

module testbench;
  import exec_pkg::*;
  logic        clk;
  logic        rst;
  logic        vld;
  logic        rd;
  logic        wr;
  logic        rdy;
  logic        done;
  logic        waitreq;
  exec_req_t   req;
  exec_res_t   res;
  logic [11:0] pc;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] seed;
  int          failures;
  int          tests_run;
  int          cyc;
  op_t         alu_op [4] = '{op_add, op_add_carry, op_sub, op_compare};
  op_t         br_op  [4] = '{op_branch_signed_ge, op_branch_signed_lt, op_branch_unsigned_ge, op_branch_int_enabled};
  op_t         lg_op  [3] = '{op_clear_bits_imm, op_set_bits_imm, op_load_all_ones};
  logic [5:0]  io_a   [3] = '{6'h05, 6'h1f, 6'h20};
  op_t         sk_op  [4] = '{op_skip_reg_bit_clear, op_skip_reg_bit_set, op_skip_io_bit_clear, op_skip_io_bit_set};
  op_t         ar_op  [4] = '{op_and, op_xor, op_inc, op_dec};

  cpu_alu_branch_exec dut_u (.core_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .req_valid_i(vld), .req_i(req),
    .req_ready_o(rdy), .done_o(done), .res_o(res), .pc_o(pc), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'h1), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitreq));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Expected byte result in [15:8] and flags in [7:0] of an add or subtract.
  function automatic logic [15:0] alu(input logic [7:0] a, b, f, input logic sub, cin);
    logic [8:0] r;
    logic [4:0] h;
    logic       v;
    r = sub ? {1'b0, a} - {1'b0, b} - cin : {1'b0, a} + {1'b0, b} + cin;
    h = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - cin : {1'b0, a[3:0]} + {1'b0, b[3:0]} + cin;
    v = sub ? (a[7] ^ b[7]) & (a[7] ^ r[7]) : ~(a[7] ^ b[7]) & (a[7] ^ r[7]);
    return {r[7:0], f[7:6], h[4], r[7] ^ v, v, r[7], r[7:0] == 8'h00, r[8]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0000_00, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20)
      failures++;
  endtask

  // Offers one operation and counts cycles from the take edge to done.
  task automatic run_op(input exec_req_t r);
    @(posedge clk);
    vld <= 1'b1;
    req <= r;
    @(posedge clk);
    vld <= 1'b0;
    cyc = 0;
    do
    begin
      @(negedge clk);
      cyc++;
    end
    while (done !== 1'b1 && cyc < 8);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    #400000;
    failures++;
    complete_run();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin : main
    exec_req_t   r;
    logic [31:0] q;
    logic [15:0] e;
    logic [15:0] m;
    logic [7:0]  f;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [11:0] p;
    logic        t;
    int          k;
    int          n;
    logic [16:0] w;
    seed = 32'h0000_5434;
    failures = 0;
    tests_run = 0;
    rst = 1'b1;
    vld = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    req = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(0, 8'hfc, 8'h00, q);
    check(q, 32'h0000_0000);
    bus(0, 8'h10, 8'h00, q);
    check(q, 32'h0000_0000);
    bus(1, 8'hf8, 8'h03, q);
    bus(0, 8'hf8, 8'h00, q);
    check(q, 32'h0000_0003);
    bus(1, 8'hf4, 8'h40, q);
    for (k = 0; k < 40; k++)
    begin
      f = 8'(rnd());
      a = 8'(rnd());
      b = 8'(rnd());
      r = '0;
      r.op = alu_op[k % 4];
      r.rd_val = a;
      r.rr_val = b;
      bus(1, 8'hfc, f, q);
      run_op(r);
      e = alu(a, b, f, k % 4 >= 2, k % 4 == 1 && f[0]);
      check(cyc, 1);
      check(res.wr_en, k % 4 != 3);
      if (k % 4 != 3)
        check(res.wr_data[7:0], e[15:8]);
      bus(0, 8'hfc, 8'h00, q);
      check(q, e[7:0]);
      r.op = k % 2 ? op_fractional_product : op_product_unsigned;
      m = {8'h00, a} * {8'h00, b};
      e = k % 2 ? {m[14:0], 1'b0} : m;
      run_op(r);
      check(cyc, 2);
      check({res.wr_word, res.wr_data}, {1'b1, e});
      bus(0, 8'hfc, 8'h00, q);
      check(q[1:0], {e == 16'h0000, m[15]});
      r.op = br_op[k % 4];
      r.offset = 12'(rnd());
      t = k % 4 == 0 ? !(q[2] ^ q[3]) : k % 4 == 1 ? q[2] ^ q[3] : k % 4 == 2 ? !q[0] : q[7];
      p = pc;
      run_op(r);
      check(cyc, t ? 2 : 1);
      check(pc, t ? 12'(p + r.offset + 12'h001) : 12'(p + 12'h001));
    end
    for (k = 0; k < 3; k++)
    begin
      r = '0;
      r.op = lg_op[k];
      r.use_imm = 1'b1;
      r.rd_val = 8'(rnd());
      r.imm = 8'(rnd());
      f = 8'(rnd());
      a = k == 0 ? r.rd_val & (8'hff - r.imm) : k == 1 ? r.rd_val | r.imm : 8'hff;
      bus(1, 8'hfc, f, q);
      run_op(r);
      check(res.wr_data[7:0], a);
      bus(0, 8'hfc, 8'h00, q);
      check(k == 2 ? q[7:0] : {5'h00, q[3:1]}, k == 2 ? f : {5'h00, 1'b0, a[7], a == 8'h00});
      r.op = k == 1 ? op_clear_io_bit : op_set_io_bit;
      r.io_addr = io_a[k];
      r.io_val = 8'(rnd());
      r.bit_sel = 3'(rnd());
      a = k == 1 ? r.io_val & ~(8'h01 << r.bit_sel) : r.io_val | (8'h01 << r.bit_sel);
      run_op(r);
      check(cyc, k < 2 ? 2 : 1);
      check({res.refused, res.io_wr_en}, k < 2 ? 2'b01 : 2'b10);
      if (k < 2)
        check({res.io_addr, res.io_data}, {io_a[k], a});
      r = '0;
      r.op = op_compare_skip_equal;
      r.rd_val = 8'h5a;
      r.rr_val = k == 2 ? 8'h5b : 8'h5a;
      r.skip_two_word = k == 1;
      p = pc;
      run_op(r);
      check(cyc, k == 2 ? 1 : k + 2);
      check(pc, 12'(p + (k == 2 ? 1 : k + 2)));
    end
    for (k = 0; k < 4; k++)
    begin
      r = '0;
      r.op = k % 2 ? op_word_imm_diff : op_word_imm_sum;
      {r.rd_hi_val, r.rd_val} = k == 0 ? 16'h7fff : k == 1 ? 16'h0000 : 16'(rnd());
      r.imm = 8'(rnd());
      m = {r.rd_hi_val, r.rd_val};
      w = k % 2 ? {1'b0, m} - r.imm[5:0] : {1'b0, m} + r.imm[5:0];
      t = k % 2 ? m[15] & !w[15] : !m[15] & w[15];
      run_op(r);
      check(cyc, 2);
      check({res.wr_word, res.wr_data}, {1'b1, w[15:0]});
      bus(0, 8'hfc, 8'h00, q);
      check(q[4:0], {w[15] ^ t, t, w[15], w[15:0] == 16'h0000, w[16]});
    end
    for (k = 0; k < 8; k++)
    begin
      r = '0;
      r.op = sk_op[k % 4];
      r.rr_val = 8'(rnd());
      r.io_val = 8'(rnd());
      r.bit_sel = 3'(rnd());
      r.skip_two_word = k[2];
      t = (k % 4 < 2 ? r.rr_val[r.bit_sel] : r.io_val[r.bit_sel]) == k[0];
      n = t ? 2 + k[2] : 1;
      p = pc;
      run_op(r);
      check(cyc, n);
      check(pc, 12'(p + n));
      r.op = k[0] ? op_branch_flag_set : op_branch_flag_clear;
      r.offset = 12'(rnd());
      f = 8'(rnd());
      bus(1, 8'hfc, f, q);
      t = f[r.bit_sel] == k[0];
      p = pc;
      run_op(r);
      check(cyc, t ? 2 : 1);
      check(pc, t ? 12'(p + r.offset + 12'h001) : 12'(p + 12'h001));
      r.op = ar_op[k % 4];
      r.rd_val = k == 2 ? 8'h7f : k == 3 ? 8'h80 : 8'(rnd());
      a = k % 4 == 0 ? r.rd_val & r.rr_val : k % 4 == 1 ? r.rd_val ^ r.rr_val :
          k % 4 == 2 ? r.rd_val + 8'h01 : r.rd_val - 8'h01;
      t = k % 4 == 2 ? r.rd_val == 8'h7f : k % 4 == 3 && r.rd_val == 8'h80;
      run_op(r);
      check(res.wr_data[7:0], a);
      bus(0, 8'hfc, 8'h00, q);
      check(q[3:1], {t, a[7], a == 8'h00});
    end
    bus(1, 8'hfc, 8'h5a, q);
    r = '0;
    r.op = op_jump_rel;
    r.offset = 12'hffe;
    p = pc;
    run_op(r);
    check(cyc, 2);
    check(pc, 12'(p + 12'hfff));
    r.op = op_indirect_call;
    r.z_ptr = 16'h0123;
    p = pc;
    run_op(r);
    check(cyc, 3);
    check({res.push_en, res.push_addr, res.push_data}, {1'b1, 10'h340, 4'h0, 12'(p + 12'h001)});
    check(pc, 12'h123);
    r.op = op_jump_ind;
    run_op(r);
    check(pc, 12'h123);
    r.op = op_relative_call;
    r.offset = 12'h010;
    p = pc;
    run_op(r);
    check(cyc, 3);
    check({res.push_addr, res.push_data, pc}, {10'h33e, 4'h0, 12'(p + 12'h001), 12'(p + 12'h011)});
    bus(0, 8'hfc, 8'h00, q);
    check(q, 32'h0000_005a);
    bus(0, 8'hf4, 8'h00, q);
    check(q, 32'h0000_003c);
    complete_run();
  end
endmodule
